// ---- design/timer_watchdog_pkg.sv ----
// Functional notes
// [RQ1] two 8-bit prescalers: timer and watchdog
// [RQ2] timer ratio field in core control
// [RQ3] watchdog ratio field in watchdog control
// [RQ4] timer write clears timer prescaler
// [RQ5] clear or sleep instruction clears watchdog
// [RQ6] timer counter is 8-bit read/write
// [RQ7] timer clock internal or external pin
// [RQ8] external mode counts selected pin edge
// [RQ9] pin phases exceed one internal clock
// [RQ10] internal clock period is fosc/2
// [RQ11] internal timer stops during sleep
// [RQ12] watchdog runs from own base, sleep too
// [RQ13] enabled watchdog time-out resets device
// [RQ14] software enables watchdog any time
// [RQ15] bypassed time-out about 18 ms
// [RQ16] source select: sub clock or fosc
// [RQ17] bits 4 and 5 pick source, edge
// [RQ18] device reset clears watchdog and prescaler
// [RQ19] ratio field divides by 2^(n+1)
// [RQ20] timer wraps, sets clearable overflow flag
package timer_watchdog_pkg;

   // register offsets on the plain register port
   localparam logic [3:0] CORE_CTRL_ADDR = 4'h0;
   localparam logic [3:0] TIMER_ADDR     = 4'h1;
   localparam logic [3:0] WDOG_CTRL_ADDR = 4'h2;
   localparam logic [3:0] MODE_ADDR      = 4'h3;
   localparam logic [3:0] STATUS_ADDR    = 4'h4;

   // field positions
   localparam int RATIO_LSB      = 0;
   localparam int EXT_SRC_BIT    = 4;
   localparam int FALL_EDGE_BIT  = 5;
   localparam int WD_BYPASS_BIT  = 3;
   localparam int WD_ENABLE_BIT  = 4;
   localparam int SRC_SELECT_BIT = 6;
   localparam int OVF_BIT        = 0;
   localparam int SLEEP_BIT      = 1;

   // values after reset
   localparam logic [7:0] CORE_CTRL_RESET = 8'h00;
   localparam logic [7:0] WDOG_CTRL_RESET = 8'h00;
   localparam logic [7:0] MODE_RESET      = 8'h00;
   localparam logic [7:0] TIMER_RESET     = 8'h00;

   // timing
   localparam int CLK_FREQ_HZ      = 50_000_000;
   localparam int SUB_FREQ_HZ      = 16_000;
   localparam int SUB_DIV_CYCLES   = CLK_FREQ_HZ / SUB_FREQ_HZ;
   localparam int FOSC_HALF_CYCLES = 2;
   localparam int WDOG_TIMEOUT_US  = 18_000;
   localparam int WDOG_TIMEOUT_TICKS = WDOG_TIMEOUT_US * (SUB_FREQ_HZ / 1000) / 1000;
   localparam int WDOG_CNT_W       = 9;

   // ratio n selects divide by 2^(n+1)
   function automatic logic [7:0] ratio_mask(input logic [2:0] ratio);
      ratio_mask = 8'((9'h002 << ratio) - 9'h001);
   endfunction

endpackage

// ---- design/ratio_prescaler.sv ----
`timescale 1ns/1ps
`default_nettype none
module ratio_prescaler (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       arst_n,
   // control
   input  wire logic       clear,
   input  wire logic [2:0] ratio,
   // ticks
   input  wire logic       tick_in,
   output logic            tick_out,
   output logic [7:0]      count
);
   logic [7:0] count_reg;
   logic [7:0] count_next;

   // 8-bit divider; clear beats a tick in the same cycle
   always_comb begin
      count_next = count_reg;
      if (clear) begin
         count_next = 8'h00;
      end else if (tick_in) begin
         count_next = count_reg + 8'h01;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         count_reg <= 8'h00;
      end else begin
         count_reg <= count_next;
      end
   end

   // pass every 2^(n+1)th input tick
   assign tick_out = tick_in && !clear
                     && ((count_reg & timer_watchdog_pkg::ratio_mask(ratio))
                         == timer_watchdog_pkg::ratio_mask(ratio)); // RQ19
   assign count = count_reg;
endmodule
`default_nettype wire

// ---- design/pin_edge_detect.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_edge_detect (
   // clock and reset
   input  wire logic clock,
   input  wire logic arst_n,
   // pin and edge choice
   input  wire logic pin,
   input  wire logic falling,
   // one-cycle edge pulse
   output logic      edge_pulse
);
   logic prev_reg;
   logic prev_next;

   // pin is synchronous; one flop of history is enough
   always_comb begin
      prev_next = pin;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= prev_next;
      end
   end

   assign edge_pulse = falling ? (prev_reg && !pin) : (!prev_reg && pin); // RQ8
endmodule
`default_nettype wire

// ---- design/timer_watchdog_prescale.sv ----
`timescale 1ns/1ps
`default_nettype none
module timer_watchdog_prescale #(
   parameter int SUB_DIV = timer_watchdog_pkg::SUB_DIV_CYCLES
) (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       arst_n,
   // register port
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic [7:0]      rdata,
   // instructions from the core
   input  wire logic       watchdog_clear_instruction,
   input  wire logic       sleep_instruction,
   input  wire logic       wake,
   // external counter pin
   input  wire logic       counter_pin,
   // outputs
   output logic            device_reset,
   output logic            sleeping
);
   // last watchdog count before the wrap, last sub divider count
   localparam logic [8:0] WD_LAST = 9'(timer_watchdog_pkg::WDOG_TIMEOUT_TICKS - 1);
   localparam logic [11:0] SUB_LAST = 12'(SUB_DIV - 1);

   // register state and next values
   logic [7:0]  core_control_register, core_next;
   logic [7:0]  wdog_ctrl_reg, wdog_ctrl_next;
   logic [7:0]  mode_reg, mode_next;
   logic [7:0]  timer_counter, timer_next;
   logic        ovf_reg, ovf_next;
   logic        sleep_reg, sleep_next;
   logic [7:0]  rdata_reg, rdata_next;
   logic [11:0] sub_cnt_reg, sub_cnt_next;
   logic        half_reg, half_next;
   logic [8:0]  wd_cnt_reg, wd_cnt_next;
   logic        wd_rst_reg, wd_rst_next;

   logic        sub_tick, fosc_tick, pin_edge, src_tick;
   logic        timer_tick, timer_write, tpre_clear;
   logic        wd_pre_tick, wd_tick, wd_clear, wd_wrap;
   logic [7:0]  tpre_count, wpre_count;

   logic [2:0]  timer_ratio_field;
   logic [2:0]  watchdog_ratio_field;
   logic        watchdog_enable_bit;
   logic        timer_source_select;

   // fields picked out of the control registers
   assign timer_ratio_field    = core_control_register[2:0]; // RQ2
   assign watchdog_ratio_field = wdog_ctrl_reg[2:0]; // RQ3
   assign watchdog_enable_bit  = wdog_ctrl_reg[timer_watchdog_pkg::WD_ENABLE_BIT];
   assign timer_source_select  = mode_reg[timer_watchdog_pkg::SRC_SELECT_BIT];

   // sub clock and fosc/2 ticks; the sub tick stands in for the rc base
   always_comb begin
      sub_cnt_next = (sub_cnt_reg == SUB_LAST) ? 12'h000 : sub_cnt_reg + 12'h001;
      half_next    = !half_reg; // RQ10
   end
   assign sub_tick  = (sub_cnt_reg == SUB_LAST); // RQ12
   assign fosc_tick = half_reg; // RQ10

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sub_cnt_reg <= 12'h000;
         half_reg    <= 1'b0;
      end else begin
         sub_cnt_reg <= sub_cnt_next;
         half_reg    <= half_next;
      end
   end

   pin_edge_detect u_edge (
      .clock      (clock),
      .arst_n     (arst_n),
      .pin        (counter_pin),
      .falling    (core_control_register[timer_watchdog_pkg::FALL_EDGE_BIT]),
      .edge_pulse (pin_edge)
   );

   // source choice; internal ticks stop in sleep, pin edges do not
   always_comb begin
      if (core_control_register[timer_watchdog_pkg::EXT_SRC_BIT]) begin // RQ17
         src_tick = pin_edge; // RQ7
      end else begin
         src_tick = (timer_source_select ? fosc_tick : sub_tick) && !sleep_reg; // RQ11 RQ16
      end
   end

   // a timer write also restarts its prescaler
   assign timer_write = wr && (addr == timer_watchdog_pkg::TIMER_ADDR);
   assign tpre_clear  = timer_write; // RQ4

   ratio_prescaler u_timer_pre (
      .clock    (clock),
      .arst_n   (arst_n),
      .clear    (tpre_clear),
      .ratio    (timer_ratio_field),
      .tick_in  (src_tick),
      .tick_out (timer_tick),
      .count    (tpre_count)
   ); // RQ1

   // watchdog prescaler may be bypassed by software
   assign wd_clear = watchdog_clear_instruction || sleep_instruction || wd_rst_reg; // RQ5 RQ18

   ratio_prescaler u_wdog_pre (
      .clock    (clock),
      .arst_n   (arst_n),
      .clear    (wd_clear),
      .ratio    (watchdog_ratio_field),
      .tick_in  (sub_tick),
      .tick_out (wd_pre_tick),
      .count    (wpre_count)
   ); // RQ1

   // bypass hands sub ticks straight to the counter; a clear still wins
   assign wd_tick = wdog_ctrl_reg[timer_watchdog_pkg::WD_BYPASS_BIT]
                    ? (sub_tick && !wd_clear) : wd_pre_tick; // RQ15
   assign wd_wrap = wd_tick && (wd_cnt_reg == WD_LAST);

   // registers, timer, watchdog and sleep state
   always_comb begin
      core_next      = core_control_register;
      wdog_ctrl_next = wdog_ctrl_reg;
      mode_next      = mode_reg;
      timer_next     = timer_counter;
      ovf_next       = ovf_reg;
      sleep_next     = sleep_reg;
      wd_cnt_next    = wd_cnt_reg;
      wd_rst_next    = 1'b0;
      rdata_next     = 8'h00;
      if (wr) begin
         case (addr)
            timer_watchdog_pkg::CORE_CTRL_ADDR: core_next = wdata;
            timer_watchdog_pkg::WDOG_CTRL_ADDR: wdog_ctrl_next = wdata; // RQ14
            timer_watchdog_pkg::MODE_ADDR: mode_next = wdata;
            timer_watchdog_pkg::STATUS_ADDR: begin
               if (wdata[timer_watchdog_pkg::OVF_BIT]) begin
                  ovf_next = 1'b0;
               end
            end
            default: ;
         endcase
      end
      // a write beats a tick in the same cycle
      if (timer_write) begin
         timer_next = wdata; // RQ6
      end else if (timer_tick) begin
         timer_next = timer_counter + 8'h01; // RQ8
         if (timer_counter == 8'hff) begin
            ovf_next = 1'b1; // RQ20
         end
      end
      // sleep is left by wake or by a watchdog reset
      if (sleep_instruction) begin
         sleep_next = 1'b1;
      end else if (wake) begin
         sleep_next = 1'b0;
      end
      // watchdog keeps counting in sleep; only enabled wraps reset
      if (wd_clear) begin
         wd_cnt_next = 9'h000; // RQ5
      end else if (wd_tick) begin
         wd_cnt_next = wd_wrap ? 9'h000 : wd_cnt_reg + 9'h001; // RQ12
         wd_rst_next = wd_wrap && watchdog_enable_bit; // RQ13
      end
      if (wd_rst_reg) begin
         sleep_next = 1'b0;
      end
      // registered read data stands only in the cycle after rd
      if (rd) begin
         case (addr)
            timer_watchdog_pkg::CORE_CTRL_ADDR: rdata_next = core_control_register;
            timer_watchdog_pkg::TIMER_ADDR: rdata_next = timer_counter; // RQ6
            timer_watchdog_pkg::WDOG_CTRL_ADDR: rdata_next = wdog_ctrl_reg;
            timer_watchdog_pkg::MODE_ADDR: rdata_next = mode_reg;
            timer_watchdog_pkg::STATUS_ADDR: begin
               rdata_next[timer_watchdog_pkg::OVF_BIT]   = ovf_reg;
               rdata_next[timer_watchdog_pkg::SLEEP_BIT] = sleep_reg;
            end
            default: rdata_next = 8'h00;
         endcase
      end
   end

   // device reset clears the watchdog path as well
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         core_control_register <= timer_watchdog_pkg::CORE_CTRL_RESET;
         wdog_ctrl_reg         <= timer_watchdog_pkg::WDOG_CTRL_RESET;
         mode_reg              <= timer_watchdog_pkg::MODE_RESET;
         timer_counter         <= timer_watchdog_pkg::TIMER_RESET;
         ovf_reg               <= 1'b0;
         sleep_reg             <= 1'b0;
         wd_cnt_reg            <= 9'h000; // RQ18
         wd_rst_reg            <= 1'b0;
         rdata_reg             <= 8'h00;
      end else begin
         core_control_register <= core_next;
         wdog_ctrl_reg         <= wdog_ctrl_next;
         mode_reg              <= mode_next;
         timer_counter         <= timer_next;
         ovf_reg               <= ovf_next;
         sleep_reg             <= sleep_next;
         wd_cnt_reg            <= wd_cnt_next;
         wd_rst_reg            <= wd_rst_next;
         rdata_reg             <= rdata_next;
      end
   end

   // outputs straight from flops
   assign rdata        = rdata_reg;
   assign device_reset = wd_rst_reg;
   assign sleeping     = sleep_reg;

   // checks
   timer_write_a: assert property (@(posedge clock) disable iff (!arst_n) // RQ6
      timer_write |=> timer_counter == $past(wdata) && tpre_count == 8'h00)
      else $error("timer write not loaded");
   prescale_clear_a: assert property (@(posedge clock) disable iff (!arst_n) // RQ4
      timer_write |=> tpre_count == 8'h00)
      else $error("timer prescaler not cleared");
   wd_clear_a: assert property (@(posedge clock) disable iff (!arst_n) // RQ5
      (watchdog_clear_instruction || sleep_instruction)
      |=> wd_cnt_reg == 9'h000 && wpre_count == 8'h00)
      else $error("watchdog not cleared");
   sleep_stop_a: assert property (@(posedge clock) disable iff (!arst_n) // RQ11
      sleep_reg && !core_control_register[timer_watchdog_pkg::EXT_SRC_BIT] && !wr
      |=> $stable(timer_counter))
      else $error("internal timer ran in sleep");
   wd_reset_a: assert property (@(posedge clock) disable iff (!arst_n) // RQ13
      device_reset |-> $past(watchdog_enable_bit) && $past(wd_cnt_reg) == WD_LAST)
      else $error("watchdog reset without time-out");
   wd_enable_a: assert property (@(posedge clock) disable iff (!arst_n) // RQ14
      wr && addr == timer_watchdog_pkg::WDOG_CTRL_ADDR
      |=> watchdog_enable_bit == $past(wdata[timer_watchdog_pkg::WD_ENABLE_BIT]))
      else $error("watchdog enable not written");
   overflow_set_a: assert property (@(posedge clock) disable iff (!arst_n) // RQ20
      timer_tick && !timer_write && timer_counter == 8'hff
      |=> timer_counter == 8'h00 && ovf_reg)
      else $error("overflow not flagged");
   half_clock_a: assert property (@(posedge clock) disable iff (!arst_n) // RQ10
      fosc_tick |=> !fosc_tick ##1 fosc_tick)
      else $error("fosc/2 tick spacing wrong");
   ext_count_a: assert property (@(posedge clock) disable iff (!arst_n) // RQ8
      !timer_write && !timer_tick |=> $stable(timer_counter))
      else $error("timer moved without tick");

   // register port read path
   rdata_idle_a: assert property (@(posedge clock) disable iff (!arst_n) // RQ6
      !rd |=> rdata == 8'h00)
      else $error("read data not idle");
   read_timer_a: assert property (@(posedge clock) disable iff (!arst_n) // RQ6
      rd && addr == timer_watchdog_pkg::TIMER_ADDR
      |=> rdata == $past(timer_counter))
      else $error("timer read wrong");

   // overflow flag is sticky until software clears it; a set wins
   ovf_sticky_a: assert property (@(posedge clock) disable iff (!arst_n) // RQ20
      ovf_reg && !(wr && addr == timer_watchdog_pkg::STATUS_ADDR
                   && wdata[timer_watchdog_pkg::OVF_BIT])
      |=> ovf_reg)
      else $error("overflow flag lost");
   ovf_clear_a: assert property (@(posedge clock) disable iff (!arst_n) // RQ20
      wr && addr == timer_watchdog_pkg::STATUS_ADDR && wdata[timer_watchdog_pkg::OVF_BIT]
      && !(timer_tick && timer_counter == 8'hff)
      |=> !ovf_reg)
      else $error("overflow flag not cleared");

   // sleep entry and exit
   sleep_enter_a: assert property (@(posedge clock) disable iff (!arst_n) // RQ11
      sleep_instruction && !wd_rst_reg |=> sleeping)
      else $error("sleep not entered");
   wake_leave_a: assert property (@(posedge clock) disable iff (!arst_n) // RQ11
      wake && !sleep_instruction |=> !sleeping)
      else $error("sleep not left");

   // watchdog counting, time-out and the reset that follows
   bypass_count_a: assert property (@(posedge clock) disable iff (!arst_n) // RQ15
      wdog_ctrl_reg[timer_watchdog_pkg::WD_BYPASS_BIT] && sub_tick && !wd_clear
      && wd_cnt_reg != WD_LAST
      |=> wd_cnt_reg == $past(wd_cnt_reg) + 9'h001)
      else $error("bypassed watchdog missed a sub tick");
   timeout_reset_a: assert property (@(posedge clock) disable iff (!arst_n) // RQ13
      wd_wrap && watchdog_enable_bit |=> device_reset)
      else $error("enabled time-out gave no reset");
   reset_clears_a: assert property (@(posedge clock) disable iff (!arst_n) // RQ18
      device_reset |=> wd_cnt_reg == 9'h000 && wpre_count == 8'h00 && !sleeping)
      else $error("device reset left watchdog running");

   // main scenarios
   wd_timeout_c: cover property (@(posedge clock) disable iff (!arst_n) device_reset);
   timer_wrap_c: cover property (@(posedge clock) disable iff (!arst_n)
      timer_tick && timer_counter == 8'hff);
   sleep_ext_c: cover property (@(posedge clock) disable iff (!arst_n)
      sleep_reg && pin_edge);
   ovf_clear_c: cover property (@(posedge clock) disable iff (!arst_n)
      wr && addr == timer_watchdog_pkg::STATUS_ADDR && ovf_reg);
endmodule
`default_nettype wire

// ---- test/pin_pulser.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_pulser #(
   parameter int PHASE = 4
) (
   // clock
   input  wire logic clock,
   // counter pin
   output logic      pin
);
   // pin idles low between bursts, so every burst starts on a rising edge
   initial pin = 1'b0;

   // n full pulses; each level is held PHASE cycles, well past one fosc/2 period
   task automatic send(input int n);
      for (int i = 0; i < 2 * n; i++) begin
         @(posedge clock);
         pin <= ~pin;
         repeat (PHASE - 1) @(posedge clock);
      end
   endtask
endmodule
`default_nettype wire

// ---- test/test_timer_watchdog_prescale.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_timer_watchdog_prescale;
   localparam int SUB_DIV = 4;
   logic       clock = 1'b0;
   logic       arst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [7:0] rdata;
   logic       wd_clr = 1'b0;
   logic       sleep_in = 1'b0;
   logic       wake = 1'b0;
   logic       counter_pin;
   logic       device_reset;
   logic       sleeping;
   logic [7:0] got;
   logic [7:0] t1;
   int         err_count = 0;
   int         n_compared = 0;
   int         n;

   // 50 MHz clock
   initial begin
      forever #10 clock = ~clock;
   end

   timer_watchdog_prescale #(.SUB_DIV(SUB_DIV)) u_dut (
      .clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .watchdog_clear_instruction(wd_clr), .sleep_instruction(sleep_in),
      .wake(wake), .counter_pin(counter_pin), .device_reset(device_reset),
      .sleeping(sleeping)
   );
   pin_pulser u_src (.clock(clock), .pin(counter_pin));

   task automatic fail(input string msg);
      err_count++;
      $display("[FAIL] %0t %s", $time, msg);
   endtask

   // exact value compare on design values
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e) fail($sformatf("got %h expected %h", g, e));
   endtask

   // window compare; an unknown never lands inside
   task automatic chk_range(input logic [15:0] g, input int lo, input int hi);
      n_compared++;
      if ((g >= lo && g <= hi) !== 1'b1) fail($sformatf("got %0d not in %0d..%0d", g, lo, hi));
   endtask

   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   // k: 0 watchdog clear, 1 sleep, 2 wake; one-cycle pulse
   task automatic instr(input int k);
      @(posedge clock);
      if (k == 0) wd_clr <= 1'b1;
      else if (k == 1) sleep_in <= 1'b1;
      else wake <= 1'b1;
      @(posedge clock);
      wd_clr <= 1'b0;
      sleep_in <= 1'b0;
      wake <= 1'b0;
   endtask

   // bounded wait; a reset pulse that never comes is a mismatch
   task automatic wait_reset(input int limit, output int cnt);
      cnt = 0;
      while (device_reset !== 1'b1 && cnt < limit) begin
         @(posedge clock);
         #1 cnt++;
      end
      if (device_reset !== 1'b1) fail("no watchdog reset in time");
   endtask

   task automatic test_reset;
      for (int a = 0; a < 6; a++) begin
         reg_rd(4'(a), got);
         chk8(got, 8'h00);
      end
      chk8({6'h00, device_reset, sleeping}, 8'h00);
      $display("test reset done");
   endtask

   task automatic test_timer_rw;
      reg_wr(timer_watchdog_pkg::TIMER_ADDR, 8'h5a);
      reg_rd(timer_watchdog_pkg::TIMER_ADDR, got);
      chk8(got, 8'h5a);
      reg_wr(timer_watchdog_pkg::TIMER_ADDR, 8'ha5);
      reg_rd(timer_watchdog_pkg::TIMER_ADDR, got);
      chk8(got, 8'ha5);
      $display("test timer rw done");
   endtask

   // edge kind and ratio table: core value, pulses, expected count
   task automatic test_ext;
      logic [7:0] cfg [4] = '{8'h10, 8'h30, 8'h11, 8'h17};
      int pulses [4] = '{4, 4, 8, 256};
      logic [7:0] expv [4] = '{8'h02, 8'h02, 8'h02, 8'h01};
      for (int i = 0; i < 4; i++) begin
         reg_wr(timer_watchdog_pkg::CORE_CTRL_ADDR, cfg[i]);
         reg_wr(timer_watchdog_pkg::TIMER_ADDR, 8'h00); // also clears the prescaler
         u_src.send(pulses[i]);
         repeat (4) @(posedge clock);
         reg_rd(timer_watchdog_pkg::TIMER_ADDR, got);
         chk8(got, expv[i]);
      end
      $display("test external pin done");
   endtask

   // fosc/2 gives one count per 4 cycles at 1:2, sub tick one per 8
   task automatic test_int;
      reg_wr(timer_watchdog_pkg::CORE_CTRL_ADDR, 8'h00);
      reg_wr(timer_watchdog_pkg::MODE_ADDR, 8'h40);
      reg_wr(timer_watchdog_pkg::TIMER_ADDR, 8'h00);
      repeat (40) @(posedge clock);
      reg_rd(timer_watchdog_pkg::TIMER_ADDR, got);
      chk_range(16'(got), 9, 12);
      reg_wr(timer_watchdog_pkg::MODE_ADDR, 8'h00);
      reg_wr(timer_watchdog_pkg::TIMER_ADDR, 8'h00);
      repeat (40) @(posedge clock);
      reg_rd(timer_watchdog_pkg::TIMER_ADDR, got);
      chk_range(16'(got), 4, 7);
      $display("test internal clock done");
   endtask

   task automatic test_sleep;
      reg_wr(timer_watchdog_pkg::MODE_ADDR, 8'h40);
      instr(1);
      #1 chk8({7'h00, sleeping}, 8'h01);
      reg_rd(timer_watchdog_pkg::STATUS_ADDR, got);
      chk8(got, 8'h02);
      reg_rd(timer_watchdog_pkg::TIMER_ADDR, t1);
      repeat (40) @(posedge clock);
      reg_rd(timer_watchdog_pkg::TIMER_ADDR, got);
      chk8(got, t1);
      instr(2);
      #1 chk8({7'h00, sleeping}, 8'h00);
      $display("test sleep done");
   endtask

   task automatic test_ovf;
      reg_wr(timer_watchdog_pkg::TIMER_ADDR, 8'hfe);
      repeat (30) @(posedge clock);
      reg_rd(timer_watchdog_pkg::STATUS_ADDR, got);
      chk8(got, 8'h01);
      reg_rd(timer_watchdog_pkg::TIMER_ADDR, got);
      chk_range(16'(got), 1, 10);
      reg_wr(timer_watchdog_pkg::STATUS_ADDR, 8'h01);
      reg_rd(timer_watchdog_pkg::STATUS_ADDR, got);
      chk8(got, 8'h00);
      $display("test overflow done");
   endtask

   // 288 sub ticks of SUB_DIV cycles each, doubled by the 1:2 prescaler when bypass is off
   task automatic test_wdog;
      // clear before enabling, so a stale count cannot trip an early reset
      instr(0);
      reg_wr(timer_watchdog_pkg::WDOG_CTRL_ADDR, 8'h18);
      wait_reset(1300, n);
      chk_range(16'(n), 1145, 1160);
      reg_wr(timer_watchdog_pkg::WDOG_CTRL_ADDR, 8'h18);
      repeat (900) @(posedge clock);
      instr(0);
      wait_reset(1300, n);
      chk_range(16'(n), 1145, 1160);
      reg_wr(timer_watchdog_pkg::WDOG_CTRL_ADDR, 8'h10);
      instr(0);
      wait_reset(2500, n);
      chk_range(16'(n), 2290, 2312);
      reg_wr(timer_watchdog_pkg::WDOG_CTRL_ADDR, 8'h18);
      repeat (500) @(posedge clock);
      instr(1);
      wait_reset(1300, n);
      chk_range(16'(n), 1145, 1160);
      @(posedge clock);
      #1 chk8({7'h00, sleeping}, 8'h00);
      // disabled: the counter wraps inside this window, yet no reset may follow
      reg_wr(timer_watchdog_pkg::WDOG_CTRL_ADDR, 8'h08);
      instr(0);
      n = 0;
      repeat (1300) begin
         @(posedge clock);
         #1;
         if (device_reset === 1'b1) n++;
      end
      chk8(8'(n), 8'h00);
      $display("test watchdog done");
   endtask

   // cut a hang short
   initial begin
      #1ms;
      fail("run limit reached");
      print_verdict();
   end

   initial begin
      repeat (8) @(posedge clock);
      arst_n <= 1'b1;
      test_reset();
      test_timer_rw();
      test_ext();
      test_int();
      test_sleep();
      test_ovf();
      test_wdog();
      print_verdict();
   end
endmodule
`default_nettype wire
